// >>> vemc_host_model.sv
// Host model that writes mode setup scripts over the register port
`timescale 1ns/1ps
module vemc_host_model
  import vemc_pkg::*;
(
  input  wire logic       clk_i,   // System clock
  input  wire logic [7:0] rdata_i, // Read data from block
  output logic      [7:0] addr_o,  // Register address
  output logic      [7:0] wdata_o, // Write data
  output logic            wr_o,    // Write strobe
  output logic            rd_o     // Read strobe
);
  // Quiet bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // one complete write at a time
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Released bus shows inverted values, never a stale copy
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  // Read answer stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask

  // soft reset first, then the script in order
  task automatic run_script(input logic fam, input logic [7:0] mode, input logic rgb,
                            input logic [7:0] stdv, input logic w10);
    wr_reg(ADDR_LOGIC_SOFT_RESET, SOFT_RESET_CMD);
    wr_reg(ADDR_DEFINITION_FAMILY, {7'h00, fam});
    wr_reg(ADDR_OUTPUT_AND_PLL_POWER, 8'h1c);
    wr_reg(ADDR_INPUT_MODE_SELECT, mode);
    // Color select only in RGB scripts
    if (rgb) begin
      wr_reg(ADDR_OUTPUT_COLOR_SELECT, 8'h10);
    end
    wr_reg(ADDR_VIDEO_STANDARD_SELECT, stdv);
    wr_reg(ADDR_PIXEL_VALID_CONTROL, 8'h01);
    if (w10) begin
      wr_reg(ADDR_INPUT_WIDTH_CONTROL, 8'h6c);
    end
  endtask
endmodule

// >>> vemc_mode_config.sv
// Register file and mode decode that set an encoder's enhanced and high definition modes
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

// What this block and its host model do
// R1: Script starts with soft reset write.
// R2: 0x1C powers three converters and PLL.
// R3: High definition gives four times PLL.
// R4: Mode 0x10 selects single rate 16-bit.
// R5: Mode 0x20 double rate, luma falling edge.
// R6: Color 0x10 gives RGB with sync.
// R7: 0x2C is 720p embedded, HD levels.
// R8: 0x28 is 720p separate sync.
// R9: 0x6C is 1080i embedded, HD levels.
// R10: 0x18 is 1080i separate sync.
// R11: 0x1C is 625p embedded, ED levels.
// R12: Pixel valid, HD four times oversampling.
// R13: Width 0x6C widens double rate to 10.
// R14: Double rate only with embedded timing; a clash is only flagged, double rate still applies.
// R15: 0x04 is 525p embedded, ED levels.
// R16: Host writes script one at a time.
module vemc_mode_config
  import vemc_pkg::*;
(
  input  wire logic       clk_sys_i,          // System clock, 100 MHz
  input  wire logic       resetn_i,           // Synchronous reset, active low
  input  wire logic [7:0] addr_i,             // Register address
  input  wire logic [7:0] wdata_i,            // Write data
  input  wire logic       wr_i,               // Write strobe
  input  wire logic       rd_i,               // Read strobe
  output logic      [7:0] rdata_o,            // Read data, cycle after strobe
  output logic      [2:0] dac_enable_o,       // Output converter enables
  output logic            pll_enable_o,       // PLL running
  output logic      [4:0] pll_ratio_o,        // PLL oversampling ratio
  output logic            single_rate_o,      // Single rate 16-bit capture
  output logic            double_rate_o,      // Double rate capture
  output logic            luma_on_fall_o,     // Luma taken on falling input edge
  output logic      [4:0] input_width_o,      // Captured word width in bits
  output logic            rgb_out_o,          // RGB instead of YPrPb
  output logic            rgb_sync_o,         // Sync pulses on RGB outputs
  output logic      [2:0] video_std_o,        // Decoded video format
  output logic            sync_embedded_o,    // Timing from embedded codes
  output logic            hd_levels_o,        // High definition output levels
  output logic            pixel_valid_o,      // Incoming pixels valid
  output logic            hd_oversample_o,    // HD path at four times
  output logic            config_error_o,     // Illegal mode combination
  output logic            logic_reset_o       // One-cycle logic reset pulse
);

  // ****************************************
  // State
  // ****************************************

  // All state in one record
  typedef struct packed {
    logic [7:0] power;        // Output and PLL power
    logic [7:0] in_mode;      // Input mode select
    logic [7:0] color;        // Output color select
    logic [7:0] soft_rst;     // Soft reset register
    logic [7:0] std_sel;      // Video standard select
    logic [7:0] pix_valid;    // Pixel valid control
    logic [7:0] width;        // Input width control
    logic [7:0] family;       // Definition family
    logic [7:0] rdata;        // Read data holding
    logic [2:0] dac_en;       // Registered converter enables
    logic       pll_en;       // Registered PLL enable
    logic [4:0] pll_ratio;    // Registered PLL ratio
    logic       sdr;          // Registered single rate
    logic       ddr;          // Registered double rate
    logic [4:0] in_width;     // Registered width
    logic       rgb;          // Registered RGB select
    logic [2:0] std_code;     // Registered format
    logic       sync_emb;     // Registered sync source
    logic       hd_lvl;       // Registered level set
    logic       pix_ok;       // Registered pixel valid
    logic       hd_os;        // Registered HD oversampling
    logic       cfg_err;      // Registered error flag
    logic       lrst;         // Logic reset pulse
  } vemc_state_s;

  vemc_state_s state;         // Current state
  vemc_state_s next_state;    // Next state

  // Decoder results from the registered standard value
  vemc_std_e   dec_std;       // Format
  logic        dec_sync_emb;  // Embedded timing
  logic        dec_hd_lvl;    // HD levels
  logic        dec_known;     // Known code

  // ****************************************
  // Standard decoder
  // ****************************************

  // Decode from stored registers so outputs follow the register file
  vemc_std_decoder u_std_dec (
    .std_reg_i       (state.std_sel),
    .family_hd_i     (state.family[FAMILY_HD_BIT]),
    .std_o           (dec_std),
    .sync_embedded_o (dec_sync_emb),
    .hd_levels_o     (dec_hd_lvl),
    .std_known_o     (dec_known)
  );

  // Address match of a write
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
    return wr && (a == off);
  endfunction

  // ****************************************
  // Next state
  // ****************************************

  // Register writes, reads and mode decode
  always_comb begin
    logic       soft_go;
    logic [2:0] mode;
    logic       is_hd;
    soft_go    = 1'b0;
    mode       = 3'h0;
    is_hd      = 1'b0;
    next_state = state;

    // R1: soft reset returns all registers to defaults
    soft_go = wr_hit(wr_i, addr_i, ADDR_LOGIC_SOFT_RESET) && (wdata_i == SOFT_RESET_CMD);
    next_state.lrst = soft_go;

    // Plain register writes; soft reset wins over nothing else since strobes are single
    if (soft_go) begin
      next_state.power     = RST_REG;
      next_state.in_mode   = RST_REG;
      next_state.color     = RST_REG;
      next_state.std_sel   = RST_REG;
      next_state.pix_valid = RST_REG;
      next_state.width     = RST_REG;
      next_state.family    = RST_REG;
      // Command bit clears itself, reads back as zero
      next_state.soft_rst  = RST_REG;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_OUTPUT_AND_PLL_POWER: begin
          next_state.power = wdata_i;
        end
        ADDR_INPUT_MODE_SELECT: begin
          next_state.in_mode = wdata_i;
        end
        ADDR_OUTPUT_COLOR_SELECT: begin
          next_state.color = wdata_i;
        end
        ADDR_LOGIC_SOFT_RESET: begin
          next_state.soft_rst = wdata_i;
        end
        ADDR_VIDEO_STANDARD_SELECT: begin
          next_state.std_sel = wdata_i;
        end
        ADDR_PIXEL_VALID_CONTROL: begin
          next_state.pix_valid = wdata_i;
        end
        ADDR_INPUT_WIDTH_CONTROL: begin
          next_state.width = wdata_i;
        end
        ADDR_DEFINITION_FAMILY: begin
          next_state.family = wdata_i;
        end
        default: begin
          // Unmapped or read-only address, write ignored
          next_state.power = state.power;
        end
      endcase
    end

    // Read data, valid only in the cycle after the strobe
    // Cleared when no read is pending, so a stale answer
    // can never pass for a fresh one
    next_state.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        ADDR_OUTPUT_AND_PLL_POWER: begin
          next_state.rdata = state.power;
        end
        ADDR_INPUT_MODE_SELECT: begin
          next_state.rdata = state.in_mode;
        end
        ADDR_OUTPUT_COLOR_SELECT: begin
          next_state.rdata = state.color;
        end
        ADDR_LOGIC_SOFT_RESET: begin
          next_state.rdata = state.soft_rst;
        end
        ADDR_VIDEO_STANDARD_SELECT: begin
          next_state.rdata = state.std_sel;
        end
        ADDR_PIXEL_VALID_CONTROL: begin
          next_state.rdata = state.pix_valid;
        end
        ADDR_INPUT_WIDTH_CONTROL: begin
          next_state.rdata = state.width;
        end
        ADDR_DEFINITION_FAMILY: begin
          next_state.rdata = state.family;
        end
        ADDR_MODE_STATUS: begin
          // Live mode summary for software
          next_state.rdata = {state.cfg_err, state.hd_os, state.pix_ok, state.sync_emb,
                              state.ddr, state.std_code};
        end
        default: begin
          // Unmapped address reads zero
          next_state.rdata = 8'h00;
        end
      endcase
    end

    // Decode of the stored configuration
    is_hd = state.family[FAMILY_HD_BIT];
    mode  = state.in_mode[IN_MODE_LSB +: 3];

    // R2: three converter enables and PLL power
    next_state.dac_en = state.power[DAC_EN_LSB +: 3];
    next_state.pll_en = ~state.power[PLL_PD_BIT];

    // R3: ratio follows family, HD four, ED eight
    // Ratio reads zero while the PLL is powered down
    if (!next_state.pll_en) begin
      next_state.pll_ratio = PLL_RATIO_OFF;
    end else if (is_hd) begin
      next_state.pll_ratio = PLL_RATIO_HD;
    end else begin
      next_state.pll_ratio = PLL_RATIO_ED;
    end

    // R4: single rate 16-bit words
    next_state.sdr = (mode == IN_MODE_SDR);
    // R5: double rate, luma on falling edge
    next_state.ddr = (mode == IN_MODE_DDR);

    // R13: width grows to 10 only in double rate
    if (next_state.sdr) begin
      next_state.in_width = WIDTH_16;
    end else if (next_state.ddr && state.width[WIDTH_10BIT_BIT]) begin
      next_state.in_width = WIDTH_10;
    end else begin
      next_state.in_width = WIDTH_8;
    end

    // R6: RGB select also adds sync
    next_state.rgb = state.color[RGB_OUT_BIT];

    // R7: format, sync source and levels from decoder
    next_state.std_code = dec_std;
    next_state.sync_emb = dec_sync_emb;
    next_state.hd_lvl   = dec_hd_lvl;

    // R12: pixel valid and HD oversampling
    next_state.pix_ok = state.pix_valid[PIXEL_VALID_BIT];
    next_state.hd_os  = state.pix_valid[PIXEL_VALID_BIT] && is_hd;

    // Limitation: the clash is only reported, the double rate setting
    // still applies so software reads back exactly what it wrote
    // R14: double rate needs embedded timing; unknown codes flagged too
    next_state.cfg_err = (next_state.ddr && !dec_sync_emb) || !dec_known;
  end

  // ****************************************
  // State register
  // ****************************************

  // Synchronous reset to defaults
  // Derived outputs settle one edge after release, from the cleared
  // registers, so the PLL shows running at eight times by then
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // All data outputs straight from flip-flops
  // Nothing is decoded after the flops, so no output can glitch
  assign rdata_o         = state.rdata;
  assign dac_enable_o    = state.dac_en;
  assign pll_enable_o    = state.pll_en;
  assign pll_ratio_o     = state.pll_ratio;
  assign single_rate_o   = state.sdr;
  assign double_rate_o   = state.ddr;
  // R5: luma edge tied to double rate
  assign luma_on_fall_o  = state.ddr;
  assign input_width_o   = state.in_width;
  assign rgb_out_o       = state.rgb;
  // R6: sync rides with RGB select
  assign rgb_sync_o      = state.rgb;
  assign video_std_o     = state.std_code;
  assign sync_embedded_o = state.sync_emb;
  assign hd_levels_o     = state.hd_lvl;
  assign pixel_valid_o   = state.pix_ok;
  assign hd_oversample_o = state.hd_os;
  assign config_error_o  = state.cfg_err;
  assign logic_reset_o   = state.lrst;

endmodule

// >>> vemc_mode_config_chk.sv
// Checker of the mode configuration block port relations
`timescale 1ns/1ps
module vemc_mode_config_chk
  import vemc_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [2:0] dac_enable_o,
  input wire logic       pll_enable_o,
  input wire logic [4:0] pll_ratio_o,
  input wire logic       single_rate_o,
  input wire logic       double_rate_o,
  input wire logic       luma_on_fall_o,
  input wire logic [4:0] input_width_o,
  input wire logic       rgb_out_o,
  input wire logic       rgb_sync_o,
  input wire logic [2:0] video_std_o,
  input wire logic       sync_embedded_o,
  input wire logic       hd_levels_o,
  input wire logic       pixel_valid_o,
  input wire logic       hd_oversample_o,
  input wire logic       config_error_o,
  input wire logic       logic_reset_o
);
  // ****************************************
  // Clocking and named sequences
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Soft reset command and its one cycle pulse
  sequence s_soft_wr;
    wr_i && addr_i == ADDR_LOGIC_SOFT_RESET && wdata_i == SOFT_RESET_CMD;
  endsequence
  sequence s_pulse;
    logic_reset_o ##1 !logic_reset_o;
  endsequence
  // Power write not overwritten or cleared in the next cycle
  sequence s_pwr_wr;
    (wr_i && addr_i == ADDR_OUTPUT_AND_PLL_POWER)
      ##1 !(wr_i && (addr_i == ADDR_OUTPUT_AND_PLL_POWER || addr_i == ADDR_LOGIC_SOFT_RESET));
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_soft_pulse: assert property (s_soft_wr ##1 !wr_i |-> s_pulse)
    else $error("soft reset pulse missing or too long");
  a_power_apply: assert property (s_pwr_wr |=>
    dac_enable_o == $past(wdata_i[4:2], 2) && pll_enable_o == !$past(wdata_i[1], 2))
    else $error("converter or PLL enable does not follow the power write");
  // A known format or HD oversampling reveals the family; the ratio follows family, not pixel valid
  a_pll_ratio: assert property (pll_enable_o && (video_std_o != 3'h0 || hd_oversample_o) |->
    pll_ratio_o == ((hd_levels_o || hd_oversample_o) ? PLL_RATIO_HD : PLL_RATIO_ED))
    else $error("PLL ratio wrong for family");
  a_sdr_width: assert property (single_rate_o |-> input_width_o == 5'h10 && !double_rate_o)
    else $error("single rate width not 16");
  a_ddr_luma: assert property (double_rate_o |-> luma_on_fall_o && input_width_o inside {5'h08, 5'h0a})
    else $error("double rate luma edge or width wrong");
  a_rgb_sync: assert property (rgb_out_o |-> rgb_sync_o)
    else $error("RGB output without sync");
  a_hd_levels: assert property (hd_levels_o == (video_std_o inside {3'h3, 3'h4}))
    else $error("output level set does not match format");
  a_ddr_sep_err: assert property (double_rate_o && !sync_embedded_o |-> config_error_o)
    else $error("double rate with separate sync not flagged");
  a_hd_os_valid: assert property (hd_oversample_o |-> pixel_valid_o)
    else $error("HD oversampling without valid pixels");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside the read answer cycle");
endmodule

// >>> vemc_pkg.sv
// Package of register offsets, field layouts and mode encodings for the video mode configuration block
package vemc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_OUTPUT_AND_PLL_POWER   = 8'h00;
  localparam logic [7:0] ADDR_INPUT_MODE_SELECT      = 8'h01;
  localparam logic [7:0] ADDR_OUTPUT_COLOR_SELECT    = 8'h02;
  localparam logic [7:0] ADDR_LOGIC_SOFT_RESET       = 8'h17;
  localparam logic [7:0] ADDR_VIDEO_STANDARD_SELECT  = 8'h30;
  localparam logic [7:0] ADDR_PIXEL_VALID_CONTROL    = 8'h31;
  localparam logic [7:0] ADDR_INPUT_WIDTH_CONTROL    = 8'h33;
  localparam logic [7:0] ADDR_DEFINITION_FAMILY      = 8'h34;
  localparam logic [7:0] ADDR_MODE_STATUS            = 8'h35;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_REG                     = 8'h00;

  // ****************************************
  // Field values and positions
  // ****************************************
  localparam logic [7:0] SOFT_RESET_CMD              = 8'h02;
  localparam int         DAC_EN_LSB                  = 2;
  localparam int         PLL_PD_BIT                  = 1;
  localparam int         IN_MODE_LSB                 = 4;
  localparam logic [2:0] IN_MODE_SD                  = 3'h0;
  localparam logic [2:0] IN_MODE_SDR                 = 3'h1;
  localparam logic [2:0] IN_MODE_DDR                 = 3'h2;
  localparam int         RGB_OUT_BIT                 = 4;
  localparam int         STD_LSB                     = 3;
  localparam int         SYNC_EMBEDDED_BIT           = 2;
  localparam int         PIXEL_VALID_BIT             = 0;
  localparam int         WIDTH_10BIT_BIT             = 2;
  localparam int         FAMILY_HD_BIT               = 0;

  // Standard field codes, bits [7:3] of the standard register
  localparam logic [4:0] STD_CODE_525P               = 5'h00;
  localparam logic [4:0] STD_CODE_625P_1080I_SEP     = 5'h03;
  localparam logic [4:0] STD_CODE_720P               = 5'h05;
  localparam logic [4:0] STD_CODE_1080I              = 5'h0d;

  // PLL oversampling ratios
  localparam logic [4:0] PLL_RATIO_ED                = 5'h08;
  localparam logic [4:0] PLL_RATIO_HD                = 5'h04;
  localparam logic [4:0] PLL_RATIO_OFF               = 5'h00;

  // Captured input word widths
  localparam logic [4:0] WIDTH_8                     = 5'h08;
  localparam logic [4:0] WIDTH_10                    = 5'h0a;
  localparam logic [4:0] WIDTH_16                    = 5'h10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    VEMC_STD_NONE  = 3'b000,
    VEMC_STD_525P  = 3'b001,
    VEMC_STD_625P  = 3'b010,
    VEMC_STD_720P  = 3'b011,
    VEMC_STD_1080I = 3'b100
  } vemc_std_e;

endpackage

// >>> vemc_std_decoder.sv
// Decoder of the video standard register into format, sync source and level set
`timescale 1ns/1ps

module vemc_std_decoder
  import vemc_pkg::*;
(
  input  wire logic [7:0] std_reg_i,       // Video standard register value
  input  wire logic       family_hd_i,     // High definition family selected
  output vemc_std_e       std_o,           // Decoded format
  output logic            sync_embedded_o, // Timing from embedded codes
  output logic            hd_levels_o,     // High definition analog levels
  output logic            std_known_o      // Value matches a known format
);

  // ****************************************
  // Format lookup
  // ****************************************

  // Family resolves the code that is shared by 625p and 1080i
  function automatic vemc_std_e decode_std(input logic [4:0] code, input logic hd);
    vemc_std_e res;
    res = VEMC_STD_NONE;
    case (code)
      STD_CODE_525P: begin
        res = hd ? VEMC_STD_NONE : VEMC_STD_525P;
      end
      STD_CODE_625P_1080I_SEP: begin
        res = hd ? VEMC_STD_1080I : VEMC_STD_625P;
      end
      STD_CODE_720P: begin
        res = hd ? VEMC_STD_720P : VEMC_STD_NONE;
      end
      STD_CODE_1080I: begin
        res = hd ? VEMC_STD_1080I : VEMC_STD_NONE;
      end
      default: begin
        res = VEMC_STD_NONE;
      end
    endcase
    return res;
  endfunction

  // Combinational decode, the caller registers it
  always_comb begin
    // R7 R8 R9 R10 R11 R15: standard from code
    std_o           = decode_std(std_reg_i[7:STD_LSB], family_hd_i);
    sync_embedded_o = std_reg_i[SYNC_EMBEDDED_BIT];
    hd_levels_o     = (std_o == VEMC_STD_720P) || (std_o == VEMC_STD_1080I);
    std_known_o     = (std_o != VEMC_STD_NONE) && (std_reg_i[1:0] == 2'h0);
  end

endmodule

// >>> video_encoder_mode_config_bench.sv
// Self-checking bench of the mode configuration block
`timescale 1ns/1ps
module video_encoder_mode_config_bench;
  import vemc_pkg::*;
  // ****************************************
  // Signals and test table
  // ****************************************
  typedef struct {
    logic fam; logic [7:0] mode; logic rgb; logic [7:0] stdv; logic w10;
    logic [2:0] std; logic emb; logic hdl; logic err;
  } vemc_case_s;
  localparam int LIMIT = 5000;         // Tests need well under a thousand cycles
  logic clk_sys_i;                     // System clock
  logic resetn_i;                      // Reset, active low
  logic [7:0] addr, wdata, rdata, d;   // Register port
  logic wr, rd;                        // Strobes
  logic [2:0] dac_en, vstd;            // Converter enables and format
  logic [4:0] ratio, width;            // PLL ratio and word width
  logic pll_en, sdr, ddr, luma, rgb_o, rgb_s, emb, hdl, pv, hdos, cerr, lrst;
  logic [26:0] seen, exp;              // Packed output snapshot
  int err_count, n_checks, cyc;        // Counters
  vemc_case_s cases[7];                // Script table
  logic [7:0] regs[7] = '{8'h00, 8'h01, 8'h02, 8'h17, 8'h30, 8'h31, 8'h33};

  // Free running clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  vemc_host_model i_host (.clk_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
                          .wr_o(wr), .rd_o(rd));
  vemc_mode_config i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .dac_enable_o(dac_en), .pll_enable_o(pll_en),
    .pll_ratio_o(ratio), .single_rate_o(sdr), .double_rate_o(ddr), .luma_on_fall_o(luma),
    .input_width_o(width), .rgb_out_o(rgb_o), .rgb_sync_o(rgb_s), .video_std_o(vstd),
    .sync_embedded_o(emb), .hd_levels_o(hdl), .pixel_valid_o(pv), .hd_oversample_o(hdos),
    .config_error_o(cerr), .logic_reset_o(lrst));
  assign seen = {vstd, emb, hdl, cerr, width, ratio, sdr, ddr, luma, hdos, rgb_o, rgb_s, pv, dac_en, pll_en};

  // ****************************************
  // Compare, verdict and hang guard
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard counts as a mismatch
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    resetn_i = 1'b0;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    cases[0] = '{1'b1, 8'h10, 1'b0, 8'h2c, 1'b0, VEMC_STD_720P, 1'b1, 1'b1, 1'b0};
    cases[1] = '{1'b1, 8'h10, 1'b1, 8'h28, 1'b0, VEMC_STD_720P, 1'b0, 1'b1, 1'b0};
    cases[2] = '{1'b1, 8'h20, 1'b0, 8'h6c, 1'b1, VEMC_STD_1080I, 1'b1, 1'b1, 1'b0};
    cases[3] = '{1'b1, 8'h10, 1'b1, 8'h18, 1'b0, VEMC_STD_1080I, 1'b0, 1'b1, 1'b0};
    cases[4] = '{1'b0, 8'h20, 1'b1, 8'h1c, 1'b0, VEMC_STD_625P, 1'b1, 1'b0, 1'b0};
    cases[5] = '{1'b0, 8'h10, 1'b0, 8'h04, 1'b0, VEMC_STD_525P, 1'b1, 1'b0, 1'b0};
    cases[6] = '{1'b1, 8'h20, 1'b0, 8'h28, 1'b0, VEMC_STD_720P, 1'b0, 1'b1, 1'b1};
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    // PLL on at eight times after reset
    check({pll_en, ratio, vstd, cerr, dac_en}, {1'b1, PLL_RATIO_ED, 3'h1, 1'b0, 3'h0});
    foreach (regs[i]) begin
      i_host.rd_reg(regs[i], d);
      check(d, RST_REG);
    end
    $display("test reset done");
    // One script per table row, outputs checked three cycles on
    foreach (cases[i]) begin
      i_host.run_script(cases[i].fam, cases[i].mode, cases[i].rgb, cases[i].stdv, cases[i].w10);
      repeat (3) @(posedge clk_sys_i);
      #1;
      exp = {cases[i].std, cases[i].emb, cases[i].hdl, cases[i].err,
             cases[i].mode == 8'h20 ? (cases[i].w10 ? WIDTH_10 : WIDTH_8) : WIDTH_16,
             cases[i].fam ? PLL_RATIO_HD : PLL_RATIO_ED, cases[i].mode != 8'h20, cases[i].mode == 8'h20,
             cases[i].mode == 8'h20, cases[i].fam, cases[i].rgb, cases[i].rgb, 1'b1, 3'h7, 1'b1};
      check(seen, exp);
      i_host.rd_reg(ADDR_VIDEO_STANDARD_SELECT, d);
      check(d, cases[i].stdv);
      $display("test script %0d done", i);
    end
    // Soft reset clears the script and reads back zero
    i_host.wr_reg(ADDR_LOGIC_SOFT_RESET, SOFT_RESET_CMD);
    #1;
    check(lrst, 1'b1);
    i_host.rd_reg(ADDR_OUTPUT_AND_PLL_POWER, d);
    check(d, RST_REG);
    i_host.rd_reg(ADDR_LOGIC_SOFT_RESET, d);
    check(d, RST_REG);
    // Unmapped place ignores writes and reads zero
    i_host.wr_reg(8'h40, 8'h5a);
    i_host.rd_reg(8'h40, d);
    check(d, 8'h00);
    $display("test soft reset and unmapped done");
    summarize();
  end
endmodule

bind vemc_mode_config vemc_mode_config_chk i_chk (.clk_sys_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .dac_enable_o, .pll_enable_o, .pll_ratio_o, .single_rate_o, .double_rate_o, .luma_on_fall_o,
  .input_width_o, .rgb_out_o, .rgb_sync_o, .video_std_o, .sync_embedded_o, .hd_levels_o, .pixel_valid_o,
  .hd_oversample_o, .config_error_o, .logic_reset_o);
